// file: src/sdic_pkg.sv
// Package: register map, bit layout, vectors and timing of the interrupt controller
package sdic_pkg;
    localparam logic [7:0] ADDR_IEN_BASE = 8'ha8;
    localparam logic [7:0] ADDR_IPR_BASE = 8'hb8;
    localparam logic [7:0] ADDR_IEN_EXT  = 8'hc8;
    localparam logic [7:0] ADDR_IPR_EXT  = 8'hf8;
    localparam logic [7:0] MASK_BASE     = 8'h9f;
    localparam logic [7:0] MASK_IPR_BASE = 8'h1f;
    localparam logic [7:0] MASK_EXT      = 8'h3f;
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam int         BIT_GLOBAL    = 7;
    localparam int         BIT_UART      = 4;
    localparam int         BIT_TIMER1    = 3;
    localparam int         BIT_EXT1      = 2;
    localparam int         BIT_TIMER0    = 1;
    localparam int         BIT_EXT0      = 0;
    localparam int         BIT_TX_ERR    = 5;
    localparam int         BIT_CH1_DONE  = 4;
    localparam int         BIT_TX_VALID  = 3;
    localparam int         BIT_CH0_DONE  = 2;
    localparam int         BIT_RX_ERR    = 1;
    localparam int         BIT_RX_VALID  = 0;
    localparam int         NUM_SRC       = 11;
    localparam int         CYC_PER_MC    = 12;
    localparam logic [3:0] SAMPLE_PHASE  = 4'h9;
    localparam logic [3:0] MC_LAST       = 4'hb;
    localparam logic [15:0] VEC_EXT0     = 16'h0003;
    localparam logic [15:0] VEC_RX_VALID = 16'h002b;
    localparam logic [15:0] VEC_TIMER0   = 16'h000b;
    localparam logic [15:0] VEC_RX_ERR   = 16'h0033;
    localparam logic [15:0] VEC_CH0      = 16'h003b;
    localparam logic [15:0] VEC_EXT1     = 16'h0013;
    localparam logic [15:0] VEC_TX_VALID = 16'h0043;
    localparam logic [15:0] VEC_CH1      = 16'h0053;
    localparam logic [15:0] VEC_TIMER1   = 16'h001b;
    localparam logic [15:0] VEC_TX_ERR   = 16'h004b;
    localparam logic [15:0] VEC_UART     = 16'h0023;
endpackage

// file: src/sdic_ctrl.sv
// Interrupt controller with five base and six serial/DMA sources
//
// Behaviour
// - Rx valid from fifo flag or done
// - Tx valid from fifo flag or done
// - Select bit only picks valid flags
// - Error requests are OR of error flags
// - Sample flags at S5P2, poll at S6P2 of the same cycle
// - Equal priority: earliest in poll order
// - Fixed eleven-source polling order
// - Base sources keep their standard vectors
// - New sources vector 002BH to 0053H
// - Extended enable register bit layout
// - Base enable register standard layout
// - Extended priority: one means high
// - Base priority register unchanged
// - All four registers bit-addressable
// - Exactly two hardware priority levels
// - Unimplemented bits ignore writes
// - Channel done flags: hardware and software
`timescale 1ns/1ps
`default_nettype none
module sdic_ctrl (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    input  wire logic [7:0]  i_sfr_wdata,
    input  wire logic        i_bit_wr,
    input  wire logic [2:0]  i_bit_sel,
    input  wire logic        i_bit_val,
    output logic [7:0]       o_sfr_rdata,
    output logic             o_sfr_hit,
    input  wire logic        i_external0_flag,
    input  wire logic        i_external1_flag,
    input  wire logic        i_timer0_overflow,
    input  wire logic        i_timer1_overflow,
    input  wire logic        i_uart_txrx_flag,
    input  wire logic        i_tx_status_dma,
    input  wire logic        i_rx_fifo_not_empty,
    input  wire logic        i_rx_complete_flag,
    input  wire logic        i_tx_fifo_not_full,
    input  wire logic        i_tx_complete_flag,
    input  wire logic [3:0]  i_rx_err_flags,
    input  wire logic [2:0]  i_tx_err_flags,
    input  wire logic        i_chan0_count_zero,
    input  wire logic        i_chan1_count_zero,
    input  wire logic [1:0]  i_done_sw_set,
    input  wire logic [1:0]  i_done_sw_clr,
    output logic [1:0]       o_chan_done,
    input  wire logic        i_reti,
    output logic             o_int_req,
    output logic [15:0]      o_int_vector,
    output logic [3:0]       o_int_src,
    input  wire logic        i_int_ack,
    output logic             o_int_taken
);
    logic [7:0] ien_base_q, ipr_base_q, ien_ext_q, ipr_ext_q;
    logic [1:0] done_q;
    logic [3:0] phase_q;
    logic [10:0] smp_q;
    logic [10:0] smp_hi_q;
    logic [10:0] raw_req;
    logic [10:0] req_pri;
    logic [10:0] src_en;
    logic        rx_valid_req, tx_valid_req, rx_err_req, tx_err_req;
    logic        act_hi_q, act_lo_q;
    logic        pend_q;
    logic [3:0]  src_q;
    logic [15:0] vec_q;
    logic        sel_found;
    logic [3:0]  sel_idx;
    logic        sel_hi;
    logic [7:0]  wr_val;

    // Valid requests follow the DMA select; nothing else is steered by it
    assign rx_valid_req = i_tx_status_dma ? i_rx_complete_flag : i_rx_fifo_not_empty;
    assign tx_valid_req = i_tx_status_dma ? i_tx_complete_flag : i_tx_fifo_not_full;
    assign rx_err_req   = |i_rx_err_flags;
    assign tx_err_req   = |i_tx_err_flags;

    // Index is polling position, 0 polled first
    assign raw_req = {i_uart_txrx_flag, tx_err_req, i_timer1_overflow, done_q[1],
                      tx_valid_req, i_external1_flag, done_q[0], rx_err_req,
                      i_timer0_overflow, rx_valid_req, i_external0_flag};
    assign src_en = {ien_base_q[sdic_pkg::BIT_UART], ien_ext_q[sdic_pkg::BIT_TX_ERR],
                     ien_base_q[sdic_pkg::BIT_TIMER1], ien_ext_q[sdic_pkg::BIT_CH1_DONE],
                     ien_ext_q[sdic_pkg::BIT_TX_VALID], ien_base_q[sdic_pkg::BIT_EXT1],
                     ien_ext_q[sdic_pkg::BIT_CH0_DONE], ien_ext_q[sdic_pkg::BIT_RX_ERR],
                     ien_base_q[sdic_pkg::BIT_TIMER0], ien_ext_q[sdic_pkg::BIT_RX_VALID],
                     ien_base_q[sdic_pkg::BIT_EXT0]};
    assign req_pri = {ipr_base_q[sdic_pkg::BIT_UART], ipr_ext_q[sdic_pkg::BIT_TX_ERR],
                      ipr_base_q[sdic_pkg::BIT_TIMER1], ipr_ext_q[sdic_pkg::BIT_CH1_DONE],
                      ipr_ext_q[sdic_pkg::BIT_TX_VALID], ipr_base_q[sdic_pkg::BIT_EXT1],
                      ipr_ext_q[sdic_pkg::BIT_CH0_DONE], ipr_ext_q[sdic_pkg::BIT_RX_ERR],
                      ipr_base_q[sdic_pkg::BIT_TIMER0], ipr_ext_q[sdic_pkg::BIT_RX_VALID],
                      ipr_base_q[sdic_pkg::BIT_EXT0]};

    // Machine-cycle phase counter, twelve core clocks per machine cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            phase_q <= 4'h0;
        end else if (phase_q == sdic_pkg::MC_LAST) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_q + 4'h1;
        end
    end

    // Snapshot at the sample phase; polled at the last phase of the same machine cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            smp_q    <= 11'h000;
            smp_hi_q <= 11'h000;
        end else if (phase_q == sdic_pkg::SAMPLE_PHASE) begin
            smp_q    <= raw_req & src_en & {11{ien_base_q[sdic_pkg::BIT_GLOBAL]}};
            smp_hi_q <= req_pri;
        end
    end

    // Fixed-order search: first high request, else first low request
    always_comb begin
        sel_found = 1'b0;
        sel_idx   = 4'h0;
        sel_hi    = 1'b0;
        for (int k = 0; k < sdic_pkg::NUM_SRC; k++) begin
            if (!sel_found && smp_q[k] && smp_hi_q[k]) begin
                sel_found = 1'b1;
                sel_idx   = 4'(k);
                sel_hi    = 1'b1;
            end
        end
        for (int k = 0; k < sdic_pkg::NUM_SRC; k++) begin
            if (!sel_found && smp_q[k]) begin
                sel_found = 1'b1;
                sel_idx   = 4'(k);
            end
        end
    end

    function automatic logic [15:0] vec_of(input logic [3:0] idx);
        case (idx)
            4'h0:    vec_of = sdic_pkg::VEC_EXT0;
            4'h1:    vec_of = sdic_pkg::VEC_RX_VALID;
            4'h2:    vec_of = sdic_pkg::VEC_TIMER0;
            4'h3:    vec_of = sdic_pkg::VEC_RX_ERR;
            4'h4:    vec_of = sdic_pkg::VEC_CH0;
            4'h5:    vec_of = sdic_pkg::VEC_EXT1;
            4'h6:    vec_of = sdic_pkg::VEC_TX_VALID;
            4'h7:    vec_of = sdic_pkg::VEC_CH1;
            4'h8:    vec_of = sdic_pkg::VEC_TIMER1;
            4'h9:    vec_of = sdic_pkg::VEC_TX_ERR;
            default: vec_of = sdic_pkg::VEC_UART;
        endcase
    endfunction

    // Request to core at end of poll cycle; two in-service levels only
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pend_q <= 1'b0;
            src_q  <= 4'h0;
            vec_q  <= 16'h0000;
        end else if (i_int_ack && pend_q) begin
            pend_q <= 1'b0;
        end else if (phase_q == sdic_pkg::MC_LAST && !pend_q && sel_found
                     && !act_hi_q && !(act_lo_q && !sel_hi)) begin
            pend_q <= 1'b1;
            src_q  <= sel_idx;
            vec_q  <= vec_of(sel_idx);
        end
    end

    logic pend_hi_q;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pend_hi_q <= 1'b0;
        end else if (phase_q == sdic_pkg::MC_LAST && !pend_q) begin
            pend_hi_q <= sel_hi;
        end
    end

    // In-service levels; return releases the higher one first
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            act_hi_q <= 1'b0;
            act_lo_q <= 1'b0;
        end else if (i_int_ack && pend_q) begin
            if (pend_hi_q) begin
                act_hi_q <= 1'b1;
            end else begin
                act_lo_q <= 1'b1;
            end
        end else if (i_reti) begin
            if (act_hi_q) begin
                act_hi_q <= 1'b0;
            end else begin
                act_lo_q <= 1'b0;
            end
        end
    end

    assign o_int_req    = pend_q;
    assign o_int_vector = vec_q;
    assign o_int_src    = src_q;
    assign o_int_taken  = i_int_ack && pend_q;

    // Channel done flags; hardware set beats every clear
    for (genvar c = 0; c < 2; c++) begin : g_done
        logic hw_set;
        logic vec_clr;
        assign hw_set  = (c == 0) ? i_chan0_count_zero : i_chan1_count_zero;
        assign vec_clr = o_int_taken && (src_q == ((c == 0) ? 4'h4 : 4'h7));
        always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
                done_q[c] <= 1'b0;
            end else if (hw_set || i_done_sw_set[c]) begin
                done_q[c] <= 1'b1;
            end else if (vec_clr || i_done_sw_clr[c]) begin
                done_q[c] <= 1'b0;
            end
        end
    end
    assign o_chan_done = done_q;

    // Byte or single-bit write; unimplemented bits are masked away
    function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] msk);
        logic [7:0] v;
        v = cur;
        if (i_bit_wr) begin
            v[i_bit_sel] = i_bit_val;
        end else begin
            v = i_sfr_wdata;
        end
        merge = v & msk;
    endfunction

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ien_base_q <= sdic_pkg::RST_REG;
            ipr_base_q <= sdic_pkg::RST_REG;
            ien_ext_q  <= sdic_pkg::RST_REG;
            ipr_ext_q  <= sdic_pkg::RST_REG;
        end else if (i_sfr_wr || i_bit_wr) begin
            if (i_sfr_addr == sdic_pkg::ADDR_IEN_BASE) begin
                ien_base_q <= merge(ien_base_q, sdic_pkg::MASK_BASE);
            end else if (i_sfr_addr == sdic_pkg::ADDR_IPR_BASE) begin
                ipr_base_q <= merge(ipr_base_q, sdic_pkg::MASK_IPR_BASE);
            end else if (i_sfr_addr == sdic_pkg::ADDR_IEN_EXT) begin
                ien_ext_q <= merge(ien_ext_q, sdic_pkg::MASK_EXT);
            end else if (i_sfr_addr == sdic_pkg::ADDR_IPR_EXT) begin
                ipr_ext_q <= merge(ipr_ext_q, sdic_pkg::MASK_EXT);
            end
        end
    end

    // Read data registered; unused bits read as zero
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_sfr_rdata <= 8'h00;
            o_sfr_hit   <= 1'b0;
        end else begin
            o_sfr_hit <= 1'b1;
            if (i_sfr_addr == sdic_pkg::ADDR_IEN_BASE) begin
                o_sfr_rdata <= ien_base_q;
            end else if (i_sfr_addr == sdic_pkg::ADDR_IPR_BASE) begin
                o_sfr_rdata <= ipr_base_q;
            end else if (i_sfr_addr == sdic_pkg::ADDR_IEN_EXT) begin
                o_sfr_rdata <= ien_ext_q;
            end else if (i_sfr_addr == sdic_pkg::ADDR_IPR_EXT) begin
                o_sfr_rdata <= ipr_ext_q;
            end else begin
                o_sfr_rdata <= 8'h00;
                o_sfr_hit   <= 1'b0;
            end
        end
    end

    logic unused_rd;
    assign unused_rd = i_sfr_rd;

    sequence s_sample;
        phase_q == sdic_pkg::SAMPLE_PHASE;
    endsequence

    chk_done_set_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_chan0_count_zero |=> done_q[0])
        else $error("done flag not set by zero count");
    chk_rx_valid_sel: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_sample ##0 (ien_base_q[sdic_pkg::BIT_GLOBAL] && ien_ext_q[sdic_pkg::BIT_RX_VALID])
        |=> smp_q[1] == $past(i_tx_status_dma ? i_rx_complete_flag : i_rx_fifo_not_empty))
        else $error("rx valid source wrong");
    chk_tx_err_or: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_sample ##0 (ien_base_q[sdic_pkg::BIT_GLOBAL] && ien_ext_q[sdic_pkg::BIT_TX_ERR]
        && (i_tx_err_flags != 3'h0)) |=> smp_q[9])
        else $error("tx error not raised");
    chk_sample_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !(phase_q == sdic_pkg::SAMPLE_PHASE) && !$past(phase_q == sdic_pkg::SAMPLE_PHASE)
        |-> $stable(smp_q))
        else $error("samples changed outside sample phase");
    chk_req_timing: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(pend_q) |-> $past(phase_q) == sdic_pkg::MC_LAST)
        else $error("request raised off poll end");
    chk_ext0_vector: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        pend_q && src_q == 4'h0 |-> vec_q == 16'h0003)
        else $error("external 0 vector wrong");
    chk_ch1_vector: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        pend_q && src_q == 4'h7 |-> vec_q == 16'h0053)
        else $error("channel 1 vector wrong");
    chk_ext_mask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        ien_ext_q[7:6] == 2'b00 && ipr_ext_q[7:6] == 2'b00)
        else $error("unused bits stored");
    chk_no_hi_nest: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        act_hi_q |-> !$rose(pend_q))
        else $error("request during high service");
    chk_poll_after: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_sample ##1 (smp_q[0] && !pend_q && !act_hi_q && !act_lo_q) ##1 1'b1[*1]
        |-> ##[0:12] (pend_q || act_hi_q || act_lo_q))
        else $error("sampled request never polled");
endmodule // sdic_ctrl
`default_nettype wire

// file: tb/sdic_cpu_model.sv
// CPU core model: acknowledges vectored requests and returns from handlers
`timescale 1ns/1ps
`default_nettype none
module sdic_cpu_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_int_req,
    input  wire logic [15:0] i_int_vector,
    input  wire logic [3:0]  i_int_src,
    input  wire logic [3:0]  i_delay,
    input  wire logic        i_ret_go,
    output logic             o_int_ack,
    output logic             o_reti,
    output logic [7:0]       o_n_taken,
    output logic [15:0]      o_last_vec,
    output logic [3:0]       o_last_src
);
    logic [3:0] wait_q;
    // Vector is taken at the edge where the acknowledge is sampled, never later
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wait_q     <= 4'h0;
            o_int_ack  <= 1'b0;
            o_n_taken  <= 8'h00;
            o_last_vec <= 16'h0000;
            o_last_src <= 4'h0;
        end else begin
            o_int_ack <= 1'b0;
            if (o_int_ack && i_int_req) begin
                o_n_taken  <= o_n_taken + 8'h01;
                o_last_vec <= i_int_vector;
                o_last_src <= i_int_src;
                wait_q     <= 4'h0;
            end else if (i_int_req && wait_q >= i_delay) begin
                o_int_ack <= 1'b1;
            end else if (i_int_req) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
    always_ff @(posedge i_core_clk) begin
        o_reti <= i_rst_n & i_ret_go;
    end
endmodule // sdic_cpu_model
`default_nettype wire

// file: tb/tb_serial_dma_interrupt_ctrl.sv
// Testbench: register access, vectoring and priority of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_serial_dma_interrupt_ctrl;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        bwr = 1'b0;
    logic [2:0]  bsel = 3'h0;
    logic        bval = 1'b0;
    logic [10:0] src_q = 11'h000;
    logic        dma_q = 1'b0;
    logic        rxdn_q = 1'b0;
    logic        txdn_q = 1'b0;
    logic [1:0]  cz_q = 2'h0;
    logic [1:0]  sw_set = 2'h0;
    logic [1:0]  sw_clr = 2'h0;
    logic        ret_go = 1'b0;
    logic [3:0]  delay = 4'h0;
    logic [2:0]  xe_q = 3'h0;
    logic        taken;
    logic [7:0]  n_tk = 8'h00;
    logic [7:0]  rdata;
    logic        hit;
    logic [1:0]  chan_done;
    logic        reti;
    logic        int_req;
    logic [15:0] vec;
    logic [3:0]  isrc;
    logic        ack;
    logic [7:0]  n_taken;
    logic [15:0] last_vec;
    logic [3:0]  last_src;
    int          err_count = 0;
    int          n_checks = 0;
    localparam logic [15:0] VEC [11] = '{16'h0003, 16'h002b, 16'h000b, 16'h0033, 16'h003b,
        16'h0013, 16'h0043, 16'h0053, 16'h001b, 16'h004b, 16'h0023};
    localparam logic [7:0] EN_A [11] = '{8'ha8, 8'hc8, 8'ha8, 8'hc8, 8'hc8, 8'ha8, 8'hc8,
        8'hc8, 8'ha8, 8'hc8, 8'ha8};
    localparam logic [2:0] EN_B [11] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4,
        3'h3, 3'h5, 3'h4};
    localparam logic [7:0] RA [4] = '{8'ha8, 8'hb8, 8'hc8, 8'hf8};
    localparam logic [7:0] RM [4] = '{8'h9f, 8'h1f, 8'h3f, 8'h3f};

    always #20 clk = ~clk;

    // Independent count of taken pulses, compared with the core model at the end
    always @(posedge clk) begin
        if (taken) n_tk <= n_tk + 8'h01;
    end

    sdic_ctrl DUT (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .i_sfr_wdata(wdata), .i_bit_wr(bwr), .i_bit_sel(bsel), .i_bit_val(bval),
        .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_external0_flag(src_q[0]),
        .i_external1_flag(src_q[5]), .i_timer0_overflow(src_q[2]),
        .i_timer1_overflow(src_q[8]), .i_uart_txrx_flag(src_q[10]), .i_tx_status_dma(dma_q),
        .i_rx_fifo_not_empty(src_q[1]), .i_rx_complete_flag(rxdn_q),
        .i_tx_fifo_not_full(src_q[6]), .i_tx_complete_flag(txdn_q),
        .i_rx_err_flags({src_q[3], xe_q}), .i_tx_err_flags({xe_q[2], src_q[9], xe_q[0]}),
        .i_chan0_count_zero(cz_q[0]), .i_chan1_count_zero(cz_q[1]), .i_done_sw_set(sw_set),
        .i_done_sw_clr(sw_clr), .o_chan_done(chan_done), .i_reti(reti), .o_int_req(int_req),
        .o_int_vector(vec), .o_int_src(isrc), .i_int_ack(ack), .o_int_taken(taken)
    );
    sdic_cpu_model CPU (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_int_req(int_req), .i_int_vector(vec),
        .i_int_src(isrc), .i_delay(delay), .i_ret_go(ret_go), .o_int_ack(ack), .o_reti(reti),
        .o_n_taken(n_taken), .o_last_vec(last_vec), .o_last_src(last_src)
    );

    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bit_wr(input logic [7:0] a, input logic [2:0] s, input logic v);
        @(posedge clk);
        addr <= a;
        bsel <= s;
        bval <= v;
        bwr <= 1'b1;
        @(posedge clk);
        bwr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] d, input logic h);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, d)
        `CHK(hit, h)
    endtask
    // Count-zero is a pulse: holding it across the acknowledge would re-set the done flag
    task automatic drive(input int i, input logic v);
        @(posedge clk);
        if (i == 4 || i == 7) begin
            cz_q[i == 7] <= v;
            @(posedge clk);
            cz_q <= 2'h0;
        end else begin
            src_q[i] <= v;
        end
    endtask
    task automatic expect_int(input logic [15:0] v, input logic [3:0] s);
        logic [7:0] n0;
        n0 = n_taken;
        for (int k = 0; k < 48 && n_taken == n0; k++) @(posedge clk);
        #1;
        `CHK(n_taken, n0 + 8'h01)
        `CHK(last_vec, v)
        `CHK(last_src, s)
        @(posedge clk);
    endtask
    task automatic expect_none();
        logic [7:0] n0;
        n0 = n_taken;
        repeat (40) @(posedge clk);
        #1;
        `CHK(n_taken, n0)
        @(posedge clk);
    endtask
    task automatic ret();
        @(posedge clk);
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int r = 0; r < 4; r++) rd_chk(RA[r], 8'h00, 1'b1);
        rd_chk(8'h90, 8'h00, 1'b0);
        for (int r = 0; r < 4; r++) begin
            wr_reg(RA[r], 8'hff);
            rd_chk(RA[r], RM[r], 1'b1);
            wr_reg(RA[r], 8'h00);
        end
        bit_wr(8'hc8, 3'h7, 1'b1);
        bit_wr(8'hc8, 3'h3, 1'b1);
        rd_chk(8'hc8, 8'h08, 1'b1);
        bit_wr(8'hc8, 3'h3, 1'b0);
        bit_wr(8'ha8, 3'h0, 1'b1);
        drive(0, 1'b1);
        expect_none();
        drive(0, 1'b0);
        bit_wr(8'ha8, 3'h0, 1'b0);
        bit_wr(8'ha8, 3'h7, 1'b1);
        for (int i = 0; i < 11; i++) begin
            bit_wr(EN_A[i], EN_B[i], 1'b1);
            drive(i, 1'b1);
            expect_int(VEC[i], 4'(i));
            drive(i, 1'b0);
            `CHK(chan_done, 2'h0)
            ret();
            bit_wr(EN_A[i], EN_B[i], 1'b0);
        end
        wr_reg(8'hc8, 8'h09);
        @(posedge clk);
        dma_q <= 1'b1;
        src_q <= 11'h042;
        expect_none();
        rxdn_q <= 1'b1;
        expect_int(VEC[1], 4'h1);
        rxdn_q <= 1'b0;
        ret();
        txdn_q <= 1'b1;
        expect_int(VEC[6], 4'h6);
        txdn_q <= 1'b0;
        src_q <= 11'h000;
        dma_q <= 1'b0;
        ret();
        wr_reg(8'hc8, 8'h20);
        wr_reg(8'hf8, 8'h20);
        wr_reg(8'ha8, 8'h83);
        delay <= 4'h6;
        src_q <= 11'h205;
        expect_int(VEC[9], 4'h9);
        src_q[9] <= 1'b0;
        expect_none();
        ret();
        expect_int(VEC[0], 4'h0);
        src_q[0] <= 1'b0;
        src_q[9] <= 1'b1;
        expect_int(VEC[9], 4'h9);
        src_q[9] <= 1'b0;
        ret();
        ret();
        expect_int(VEC[2], 4'h2);
        src_q <= 11'h000;
        ret();
        wr_reg(8'hc8, 8'h10);
        sw_set <= 2'h2;
        @(posedge clk);
        sw_set <= 2'h0;
        expect_int(VEC[7], 4'h7);
        ret();
        sw_set <= 2'h1;
        @(posedge clk);
        sw_set <= 2'h0;
        sw_clr <= 2'h1;
        #1;
        `CHK(chan_done, 2'h1)
        @(posedge clk);
        sw_clr <= 2'h0;
        #1;
        `CHK(chan_done, 2'h0)
        // Error requests from other flag bits, with the DMA select set
        wr_reg(8'hc8, 8'h02);
        dma_q <= 1'b1;
        xe_q <= 3'h1;
        expect_int(VEC[3], 4'h3);
        xe_q <= 3'h4;
        wr_reg(8'hc8, 8'h20);
        expect_int(VEC[9], 4'h9);
        xe_q <= 3'h0;
        dma_q <= 1'b0;
        ret();
        ret();
        // Base priority register lifts timer 0 above external 0
        wr_reg(8'hb8, 8'h02);
        src_q <= 11'h005;
        expect_int(VEC[2], 4'h2);
        src_q <= 11'h000;
        ret();
        `CHK(n_tk, n_taken)
        close_out();
    end
    initial begin
        #1000000;
        err_count++;
        close_out();
    end
endmodule // tb_serial_dma_interrupt_ctrl
`default_nettype wire
